// ==== src/kbli_line_filter.sv ====
// one key line: qualifies an active level, directly or after a debounce interval
`timescale 1ns/1ps
`default_nettype none
module kbli_line_filter (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // line level matches its programmed level
    input wire logic active_i,
    input wire kbli_pkg::kbli_deb_cfg_t cfg_i,
    // qualified detection
    output logic detect_o
);

    logic [kbli_pkg::KBLI_DEB_CW-1:0] count;

    // the counter only runs while the line holds its level; any drop restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            detect_o <= 1'b0;
        end else if (ce_i) begin
            if (!active_i) begin
                count <= '0;
                detect_o <= 1'b0;
            end else if (cfg_i.bypass) begin
                detect_o <= 1'b1;
            end else if (count >= cfg_i.limit - 1'b1) begin
                detect_o <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && active_i && cfg_i.bypass |=> detect_o;
    endproperty
    chk_bypass_direct: assert property (p_bypass) else $error("bypass did not detect");

    chk_drop_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !active_i |=> !detect_o && count == '0)
        else $error("level drop did not restart filter");

    chk_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !cfg_i.bypass && $rose(detect_o) |-> count + 1'b1 >= cfg_i.limit)
        else $error("detect before debounce interval");

endmodule
`default_nettype wire

// ==== src/kbli_pkg.sv ====
// constants, field layouts and carrier types of the keypad level interrupt unit
// Overview of operation
// - eight independent key lines, each interrupting on a chosen level, not edge
// - a detected key level wakes the processor from idle and from stop
// - all lines merge into one request at one shared vector, flagged per line
// - routing bit clear takes the lines from port 2, set from port 0
// - level select bit 0 detects low, 1 detects high, per line
// - enable 0 leaves the pin plain I/O; 1 lets its flag request an interrupt
// - hardware sets a line flag whenever the line sits at its active level
// - the request is the OR over lines of flag AND enable
// - a set flag stays set until software writes it to zero
// - debounce control bit 0 filters the inputs, 1 passes them unfiltered
// - debounce field 00/01/10/11 selects 320/160/80/40 ms
// - all registers reset to zero: port 2, low level, plain I/O, 320 ms
package kbli_pkg;

    localparam int KBLI_LINES = 8;
    localparam int KBLI_DEB_CW = 24;

    // register indices; byte address is four times the index
    localparam logic [7:0] KBLI_IDX_ROUTE = 8'h91;
    localparam logic [7:0] KBLI_IDX_LEVEL = 8'h93;
    localparam logic [7:0] KBLI_IDX_ENABLE = 8'h94;
    localparam logic [7:0] KBLI_IDX_FLAGS = 8'h95;
    localparam logic [7:0] KBLI_IDX_DEBOUNCE = 8'h96;
    localparam logic [7:0] KBLI_IDX_EVT_STATUS = 8'h97;
    localparam logic [7:0] KBLI_IDX_EVT_MASK = 8'h98;

    // field positions
    localparam int KBLI_ROUTE_BIT = 2;
    localparam int KBLI_DEB_DIS_BIT = 7;
    localparam int KBLI_DEB_SEL_LSB = 0;
    localparam int KBLI_EVT_DETECT = 0;
    localparam int KBLI_EVT_WAKE = 1;
    localparam int KBLI_EVT_BITS = 2;

    // values after reset
    localparam logic [7:0] KBLI_RST_BYTE = 8'h00;
    localparam logic [1:0] KBLI_RST_EVT = 2'h0;

    // debounce times and the clock they are counted in
    localparam int KBLI_CLK_KHZ = 40000;
    localparam int KBLI_DEB_320_MS = 320;
    localparam int KBLI_DEB_160_MS = 160;
    localparam int KBLI_DEB_80_MS = 80;
    localparam int KBLI_DEB_40_MS = 40;
    localparam int KBLI_DEB_320_CYC = KBLI_DEB_320_MS * KBLI_CLK_KHZ;
    localparam int KBLI_DEB_160_CYC = KBLI_DEB_160_MS * KBLI_CLK_KHZ;
    localparam int KBLI_DEB_80_CYC = KBLI_DEB_80_MS * KBLI_CLK_KHZ;
    localparam int KBLI_DEB_40_CYC = KBLI_DEB_40_MS * KBLI_CLK_KHZ;

    // debounce settings handed to every line filter
    typedef struct packed {
        logic bypass;
        logic [KBLI_DEB_CW-1:0] limit;
    } kbli_deb_cfg_t;

endpackage

// ==== src/kbli_top.sv ====
// keypad level interrupt unit: pin routing, synchronisers, flags and wishbone registers
`timescale 1ns/1ps
`default_nettype none
module kbli_top #(
    parameter int DEB_CYC_320 = kbli_pkg::KBLI_DEB_320_CYC,
    parameter int DEB_CYC_160 = kbli_pkg::KBLI_DEB_160_CYC,
    parameter int DEB_CYC_80 = kbli_pkg::KBLI_DEB_80_CYC,
    parameter int DEB_CYC_40 = kbli_pkg::KBLI_DEB_40_CYC
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // key pins of both candidate ports
    input wire logic [7:0] port2_pins_i,
    input wire logic [7:0] port0_pins_i,
    // pin function: high where the pin serves as a key line
    output logic [7:0] port2_key_sel_o,
    output logic [7:0] port0_key_sel_o,
    // power state and wake-up
    input wire logic idle_i,
    input wire logic stop_i,
    output logic wake_o,
    // shared keyboard request and event interrupt
    output logic kbd_req_o,
    output logic irq_o
);

    localparam int N = kbli_pkg::KBLI_LINES;

    logic key_port_route_bit;
    logic debounce_disable_bit;
    logic [1:0] debounce_time_select;
    logic [N-1:0] key_level_select;
    logic [N-1:0] key_line_enable;
    logic [N-1:0] key_line_flag;
    logic [kbli_pkg::KBLI_EVT_BITS-1:0] evt_status;
    logic [kbli_pkg::KBLI_EVT_BITS-1:0] evt_mask;
    logic [N-1:0] p2_meta;
    logic [N-1:0] p2_sync;
    logic [N-1:0] p0_meta;
    logic [N-1:0] p0_sync;
    logic [N-1:0] key_input_line;
    logic [N-1:0] line_active;
    logic [N-1:0] line_detect;
    logic [N-1:0] line_detect_q;
    logic [kbli_pkg::KBLI_EVT_BITS-1:0] evt_set;
    logic [7:0] wb_wbyte;
    logic [7:0] rd_byte;
    logic bus_req;
    logic wr_lane;
    logic wr_route;
    logic wr_level;
    logic wr_enable;
    logic wr_flags;
    logic wr_debounce;
    logic wr_status;
    logic wr_mask;
    logic sleeping;
    kbli_pkg::kbli_deb_cfg_t deb_cfg;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone: one ack per request, answered in the cycle after it is seen

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wbyte = wb_dat_i[7:0];
    assign wr_lane = bus_req && wb_we_i && wb_sel_i[0] && ce_i;
    assign wr_route = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_ROUTE;
    assign wr_level = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_LEVEL;
    assign wr_enable = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_ENABLE;
    assign wr_flags = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_FLAGS;
    assign wr_debounce = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_DEBOUNCE;
    assign wr_status = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_EVT_STATUS;
    assign wr_mask = wr_lane && wb_adr_i[9:2] == kbli_pkg::KBLI_IDX_EVT_MASK;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
        end
    end

    // unmapped indices and bits above the byte read as zero
    always_comb begin
        rd_byte = kbli_pkg::KBLI_RST_BYTE;
        unique case (wb_adr_i[9:2])
            kbli_pkg::KBLI_IDX_ROUTE: rd_byte[kbli_pkg::KBLI_ROUTE_BIT] = key_port_route_bit;
            kbli_pkg::KBLI_IDX_LEVEL: rd_byte = key_level_select;
            kbli_pkg::KBLI_IDX_ENABLE: rd_byte = key_line_enable;
            kbli_pkg::KBLI_IDX_FLAGS: rd_byte = key_line_flag;
            kbli_pkg::KBLI_IDX_DEBOUNCE: begin
                rd_byte[kbli_pkg::KBLI_DEB_DIS_BIT] = debounce_disable_bit;
                rd_byte[kbli_pkg::KBLI_DEB_SEL_LSB +: 2] = debounce_time_select;
            end
            kbli_pkg::KBLI_IDX_EVT_STATUS: rd_byte[1:0] = evt_status;
            kbli_pkg::KBLI_IDX_EVT_MASK: rd_byte[1:0] = evt_mask;
            default: rd_byte = kbli_pkg::KBLI_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && bus_req) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, all zero after reset

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_port_route_bit <= 1'b0;
            debounce_disable_bit <= 1'b0;
            debounce_time_select <= 2'h0;
            key_level_select <= kbli_pkg::KBLI_RST_BYTE;
            key_line_enable <= kbli_pkg::KBLI_RST_BYTE;
            evt_mask <= kbli_pkg::KBLI_RST_EVT;
        end else begin
            if (wr_route) begin
                key_port_route_bit <= wb_wbyte[kbli_pkg::KBLI_ROUTE_BIT];
            end
            if (wr_level) begin
                key_level_select <= wb_wbyte;
            end
            if (wr_enable) begin
                key_line_enable <= wb_wbyte;
            end
            if (wr_debounce) begin
                debounce_disable_bit <= wb_wbyte[kbli_pkg::KBLI_DEB_DIS_BIT];
                debounce_time_select <= wb_wbyte[kbli_pkg::KBLI_DEB_SEL_LSB +: 2];
            end
            if (wr_mask) begin
                evt_mask <= wb_wbyte[1:0];
            end
        end
    end

    // pins hand over to the key function only where the line is enabled
    assign port2_key_sel_o = key_line_enable & {N{~key_port_route_bit}};
    assign port0_key_sel_o = key_line_enable & {N{key_port_route_bit}};

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; both ports are synchronised so a route change needs no refill

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p2_meta <= kbli_pkg::KBLI_RST_BYTE;
            p2_sync <= kbli_pkg::KBLI_RST_BYTE;
            p0_meta <= kbli_pkg::KBLI_RST_BYTE;
            p0_sync <= kbli_pkg::KBLI_RST_BYTE;
        end else if (ce_i) begin
            p2_meta <= port2_pins_i;
            p2_sync <= p2_meta;
            p0_meta <= port0_pins_i;
            p0_sync <= p0_meta;
        end
    end

    assign key_input_line = key_port_route_bit ? p0_sync : p2_sync;

    ////////////////////////////////////////////////////////////////////////////
    // level detection and debounce, one filter per line

    // the time field maps to the interval; the longest is the reset choice
    always_comb begin
        deb_cfg.bypass = debounce_disable_bit;
        unique case (debounce_time_select)
            2'h0: deb_cfg.limit = DEB_CYC_320[kbli_pkg::KBLI_DEB_CW-1:0];
            2'h1: deb_cfg.limit = DEB_CYC_160[kbli_pkg::KBLI_DEB_CW-1:0];
            2'h2: deb_cfg.limit = DEB_CYC_80[kbli_pkg::KBLI_DEB_CW-1:0];
            2'h3: deb_cfg.limit = DEB_CYC_40[kbli_pkg::KBLI_DEB_CW-1:0];
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_line
            // a level, not an edge: the flag keeps being set while the key is held
            assign line_active[gi] = key_input_line[gi] == key_level_select[gi];

            kbli_line_filter u_filter (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .active_i(line_active[gi]),
                .cfg_i(deb_cfg),
                .detect_o(line_detect[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // per-line flags: software clears by writing zero, writing one has no effect

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_line_flag <= kbli_pkg::KBLI_RST_BYTE;
        end else if (ce_i) begin
            // a detection in the clearing cycle wins over the clear
            if (wr_flags) begin
                key_line_flag <= (key_line_flag & wb_wbyte) | line_detect;
            end else begin
                key_line_flag <= key_line_flag | line_detect;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared request, wake-up and event interrupt

    assign sleeping = idle_i || stop_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kbd_req_o <= 1'b0;
            wake_o <= 1'b0;
        end else if (ce_i) begin
            kbd_req_o <= |(key_line_flag & key_line_enable);
            wake_o <= sleeping && |(key_line_flag & key_line_enable);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_detect_q <= kbli_pkg::KBLI_RST_BYTE;
        end else if (ce_i) begin
            line_detect_q <= line_detect;
        end
    end

    // rising detection on an enabled line, and a wake-up being raised
    assign evt_set[kbli_pkg::KBLI_EVT_DETECT] = |(line_detect & ~line_detect_q & key_line_enable);
    assign evt_set[kbli_pkg::KBLI_EVT_WAKE] = sleeping && |(key_line_flag & key_line_enable) && !wake_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status <= kbli_pkg::KBLI_RST_EVT;
        end else if (ce_i) begin
            if (wr_status) begin
                evt_status <= (evt_status & ~wb_wbyte[1:0]) | evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
        end
    end

    assign irq_o = |(evt_status & evt_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_sync_depth: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i ##1 ce_i |=> p2_sync == $past(port2_pins_i, 2) && p0_sync == $past(port0_pins_i, 2))
        else $error("pin synchroniser depth wrong");

    chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && |line_detect |=> (key_line_flag & $past(line_detect)) == $past(line_detect))
        else $error("detected line did not set its flag");

    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_flags |=> (key_line_flag & $past(key_line_flag)) == $past(key_line_flag))
        else $error("flag dropped without a software write");

    chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_flags && line_detect == 8'h00 |=> key_line_flag == $past(key_line_flag & wb_wbyte))
        else $error("flag write of zero did not clear");

    property p_req_merge;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> kbd_req_o == $past(|(key_line_flag & key_line_enable));
    endproperty
    chk_req_merge: assert property (p_req_merge) else $error("request is not or of flag and enable");

    chk_wake_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sleeping && |(key_line_flag & key_line_enable) |=> wake_o)
        else $error("wake-up missing while asleep");

    chk_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> key_line_flag == 8'h00 && key_line_enable == 8'h00
            && key_level_select == 8'h00 && !key_port_route_bit
            && !debounce_disable_bit && debounce_time_select == 2'h0)
        else $error("register not zero after reset");

    chk_route_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_route |=> port0_key_sel_o == ($past(wb_wbyte[2]) ? key_line_enable : 8'h00))
        else $error("routing bit does not steer pins");

    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held for two cycles");

    cov_flag_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(kbd_req_o));
    cov_wake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wake_o));
    cov_port0: cover property (@(posedge clk_i) disable iff (rst_i)
        key_port_route_bit && |key_line_flag);
    cov_clear_race: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_flags && |(line_detect & ~wb_wbyte));

endmodule
`default_nettype wire

// ==== testbench/kbli_key_model.sv ====
// key matrix model: presents key levels on the routed port, junk on the other
`timescale 1ns/1ps
`default_nettype none
module kbli_key_model (
    // clock
    input wire logic clk_i,
    // which port carries the keys, and their levels
    input wire logic use_port0_i,
    input wire logic [7:0] key_level_i,
    // pins of both ports
    output logic [7:0] port2_pins_o,
    output logic [7:0] port0_pins_o
);
    logic [7:0] junk = 8'h00;

    // the port not carrying keys shows a pattern that changes every cycle
    always @(posedge clk_i) begin
        junk <= junk + 8'h3B;
    end

    assign port2_pins_o = use_port0_i ? junk : key_level_i;
    assign port0_pins_o = use_port0_i ? key_level_i : junk;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench of the keypad level interrupt unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [9:0] wb_adr = 10'h000;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wake_o, kbd_req_o, irq_o, idle = 1'b0, stop = 1'b0, use_p0 = 1'b0;
    logic ce = 1'b1;
    logic [7:0] keys = 8'hF0, p2_pins, p0_pins, p2_sel, p0_sel;
    int num_errors = 0;
    int num_checks = 0;

    always #12.5 clk_i = ~clk_i;

    kbli_key_model keys_m (.clk_i(clk_i), .use_port0_i(use_p0), .key_level_i(keys),
        .port2_pins_o(p2_pins), .port0_pins_o(p0_pins));

    // small debounce counts keep the run short: 16/8/4/2 cycles
    kbli_top #(.DEB_CYC_320(16), .DEB_CYC_160(8), .DEB_CYC_80(4), .DEB_CYC_40(2)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port2_pins_i(p2_pins), .port0_pins_i(p0_pins),
        .port2_key_sel_o(p2_sel), .port0_key_sel_o(p0_sel),
        .idle_i(idle), .stop_i(stop), .wake_o(wake_o), .kbd_req_o(kbd_req_o), .irq_o(irq_o));

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one classic cycle; the request holds until ack is seen at a rising edge
    // no cycle limit here: only the watchdog ends a wait
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hF;
        wb_dat <= {24'h000000, wd};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, idx, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        xfer(1'b0, idx, 8'h00, got);
        `CHK(got, {24'h000000, exp})
    endtask

    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask

    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, num_errors);
    endtask

    // a pulse shorter than the interval must not set the flag; a long hold must
    task automatic debounce_case(input logic [1:0] code, input int lim);
        wr(kbli_pkg::KBLI_IDX_DEBOUNCE, {6'h00, code});
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        @(posedge clk_i) keys <= 8'hF1;
        repeat (lim / 2) @(posedge clk_i);
        keys <= 8'hF0;
        settle();
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        @(posedge clk_i) keys <= 8'hF1;
        repeat (lim + 8) @(posedge clk_i);
        keys <= 8'hF0;
        settle();
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h01);
    endtask

    initial begin
        #(25ns * 6000);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        logic [7:0] regs [7];
        regs = '{8'h91, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, and an unmapped index that ignores writes
        foreach (regs[i]) rd_chk(regs[i], kbli_pkg::KBLI_RST_BYTE);
        `CHK({kbd_req_o, irq_o, wake_o, p2_sel, p0_sel}, 19'h0)
        wr(8'h92, 8'hFF);
        rd_chk(8'h92, 8'h00);
        test_end("reset");
        // read-back, routing and pin function
        wr(kbli_pkg::KBLI_IDX_LEVEL, 8'h0F);
        wr(kbli_pkg::KBLI_IDX_ENABLE, 8'h5B);
        rd_chk(kbli_pkg::KBLI_IDX_LEVEL, 8'h0F);
        rd_chk(kbli_pkg::KBLI_IDX_ENABLE, 8'h5B);
        `CHK({p2_sel, p0_sel}, 16'h5B00)
        wr(kbli_pkg::KBLI_IDX_ROUTE, 8'hFF);
        rd_chk(kbli_pkg::KBLI_IDX_ROUTE, 8'h04);
        `CHK({p2_sel, p0_sel}, 16'h005B)
        wr(kbli_pkg::KBLI_IDX_ROUTE, 8'h00);
        test_end("registers");
        // unfiltered level detection on port 2; port 0 carries junk
        wr(kbli_pkg::KBLI_IDX_DEBOUNCE, 8'h80);
        wr(kbli_pkg::KBLI_IDX_ENABLE, 8'h01);
        settle();
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        `CHK(kbd_req_o, 1'b0)
        @(posedge clk_i) keys <= 8'h71;
        settle();
        keys <= 8'hF0;
        settle();
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h81);
        `CHK(kbd_req_o, 1'b1)
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h80);
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h80);
        `CHK(kbd_req_o, 1'b0)
        test_end("detect");
        // routed to port 0, line 3 high
        wr(kbli_pkg::KBLI_IDX_ROUTE, 8'h04);
        use_p0 <= 1'b1;
        settle();
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        @(posedge clk_i) keys <= 8'hF8;
        settle();
        keys <= 8'hF0;
        settle();
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h08);
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        test_end("route");
        // wake from idle and from stop
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_i) {stop, idle} <= (m == 0) ? 2'b01 : 2'b10;
            `CHK(wake_o, 1'b0)
            @(posedge clk_i) keys <= 8'hF1;
            settle();
            keys <= 8'hF0;
            `CHK(wake_o, 1'b1)
            // a level still in the pipeline would set the flag again over the clear
            settle();
            wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
            settle();
            `CHK(wake_o, 1'b0)
        end
        {stop, idle} <= 2'b00;
        test_end("wake");
        // event status, mask and the interrupt line
        rd_chk(kbli_pkg::KBLI_IDX_EVT_STATUS, 8'h03);
        `CHK(irq_o, 1'b0)
        wr(kbli_pkg::KBLI_IDX_EVT_MASK, 8'h02);
        `CHK(irq_o, 1'b1)
        wr(kbli_pkg::KBLI_IDX_EVT_STATUS, 8'h02);
        rd_chk(kbli_pkg::KBLI_IDX_EVT_STATUS, 8'h01);
        `CHK(irq_o, 1'b0)
        wr(kbli_pkg::KBLI_IDX_EVT_MASK, 8'h03);
        `CHK(irq_o, 1'b1)
        wr(kbli_pkg::KBLI_IDX_EVT_STATUS, 8'h01);
        `CHK(irq_o, 1'b0)
        test_end("interrupt");
        // debounce on at each interval
        debounce_case(2'b00, 16);
        debounce_case(2'b01, 8);
        debounce_case(2'b10, 4);
        debounce_case(2'b11, 2);
        test_end("debounce");
        // clock enable low: a key press while frozen leaves no trace
        wr(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        @(posedge clk_i) ce <= 1'b0;
        keys <= 8'hF1;
        settle();
        keys <= 8'hF0;
        @(posedge clk_i) ce <= 1'b1;
        settle();
        rd_chk(kbli_pkg::KBLI_IDX_FLAGS, 8'h00);
        test_end("freeze");
        conclude();
    end
endmodule
`default_nettype wire
